// >>> verilog/scr_rst_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module scr_rst_ctrl #(
  parameter int QID_W = 16,
  parameter logic SSR_SUPPORTED = 1'b1,
  parameter int SSR_CYCLES = scr_pkg::SSR_CYC
) (
  // Clock and synchronous active-low reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire scr_pkg::scr_axi_m2s_t axi_m2s,
  output var scr_pkg::scr_axi_s2m_t axi_s2m,
  // Asynchronous reset sources from the link and platform.
  input wire logic conv_rst_req,
  input wire logic link_down,
  input wire logic flr_req,
  input wire logic vendor_ssr_evt,
  // Controller core status and queue deletion commands.
  input wire logic core_idle,
  input wire logic qdel_cmd_valid,
  input wire logic [QID_W-1:0] qdel_cmd_qid,
  // Reset controls towards the core and the link.
  output logic ctrl_reset,
  output logic io_queues_delete,
  output logic cfg_space_reset,
  output logic host_link_lost,
  output logic pcie_detect_req,
  output logic controller_enable_bit,
  output logic controller_ready_flag,
  output var scr_pkg::scr_admin_t admin_regs,
  // Per-queue abort request.
  output logic qabort_valid,
  output logic [QID_W-1:0] qabort_qid,
  // Interrupt.
  output logic irq
);

  localparam int SSR_CW = $clog2(SSR_CYCLES + 1);

  typedef struct packed {
    scr_pkg::scr_phase_t ph;
    logic enable;
    logic rdy;
    logic ssro;
    scr_pkg::scr_admin_t adm;
    logic [scr_pkg::NEV-1:0] ist;
    logic [scr_pkg::NEV-1:0] imsk;
    logic [scr_pkg::NSRC-1:0] cause;
    logic [scr_pkg::NSRC-1:0] src_prev;
    logic [SSR_CW-1:0] ssr_cnt;
    logic crst;
    logic qdel;
    logic cfgr;
    logic lost;
    logic det;
    logic irq;
    logic abv;
    logic [QID_W-1:0] abq;
  } scr_top_st_t;

  scr_top_st_t st_r;
  scr_top_st_t st_nxt;

  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic [3:0] pins_s;
  logic conv_s;
  logic link_s;
  logic flr_s;
  logic vnd_s;
  logic ssr_go;
  logic en_fall;
  logic [31:0] wv;
  logic [scr_pkg::NSRC-1:0] src;
  logic [scr_pkg::NEV-1:0] ev;

  // Bus front end.
  scr_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .m2s(axi_m2s),
    .s2m(axi_s2m),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Pin sources pass two flip-flops before any use.
  scr_sync #(.W(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({vendor_ssr_evt, flr_req, link_down, conv_rst_req}),
    .q(pins_s)
  );

  assign conv_s = pins_s[0];
  assign link_s = pins_s[1];
  assign flr_s = pins_s[2];
  assign vnd_s = pins_s[3];

  // Unmapped offsets answer with an error on both channels.
  assign wr_err = !scr_pkg::reg_known(wr_addr);
  assign rd_err = !scr_pkg::reg_known(rd_addr);

  // Read data for the offset the bus front end holds.
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      scr_pkg::OFF_CAP: begin
        rd_data[scr_pkg::CAP_SSRS_BIT] = SSR_SUPPORTED;
      end
      scr_pkg::OFF_CFG: rd_data[scr_pkg::CFG_EN_BIT] = st_r.enable;
      scr_pkg::OFF_STS: begin
        rd_data[scr_pkg::STS_RDY_BIT] = st_r.rdy;
        rd_data[scr_pkg::STS_SSR_SEEN_BIT] = st_r.ssro;
      end
      scr_pkg::OFF_ADM_ATTR: rd_data = st_r.adm.attr;
      scr_pkg::OFF_ADM_SUB_LO: rd_data = st_r.adm.sub_lo;
      scr_pkg::OFF_ADM_SUB_HI: rd_data = st_r.adm.sub_hi;
      scr_pkg::OFF_ADM_CPL_LO: rd_data = st_r.adm.cpl_lo;
      scr_pkg::OFF_ADM_CPL_HI: rd_data = st_r.adm.cpl_hi;
      scr_pkg::OFF_IRQ_ST: rd_data[scr_pkg::NEV-1:0] = st_r.ist;
      scr_pkg::OFF_IRQ_MSK: rd_data[scr_pkg::NEV-1:0] = st_r.imsk;
      scr_pkg::OFF_CAUSE: rd_data[scr_pkg::NSRC-1:0] = st_r.cause;
      default: rd_data = 32'h0;
    endcase
  end

  // Register writes, reset sequencing, queue aborts and interrupt.
  always_comb begin
    st_nxt = st_r;
    st_nxt.qdel = 1'b0;
    st_nxt.det = 1'b0;
    st_nxt.abv = 1'b0;
    ssr_go = 1'b0;
    en_fall = 1'b0;
    wv = 32'h0;
    ev = '0;
    if (wr_pulse) begin
      unique case (wr_addr)
        scr_pkg::OFF_CFG: begin
          wv = scr_pkg::strb_merge({31'h0, st_r.enable}, wr_data, wr_strb);
          // Enable is frozen while a reset is under way.
          if (st_r.ph == scr_pkg::PH_RUN) begin
            st_nxt.enable = wv[scr_pkg::CFG_EN_BIT];
            en_fall = st_r.enable && !wv[scr_pkg::CFG_EN_BIT];
          end
        end
        scr_pkg::OFF_STS: begin
          if (wr_strb[0] && wr_data[scr_pkg::STS_SSR_SEEN_BIT]) begin
            st_nxt.ssro = 1'b0;
          end
        end
        scr_pkg::OFF_SSR_KEY: begin
          // full key write starts a subsystem reset.
          if (SSR_SUPPORTED && wr_strb == 4'hf
              && wr_data == scr_pkg::SSR_KEY) begin
            ssr_go = 1'b1;
          end
        end
        scr_pkg::OFF_ADM_ATTR: begin
          st_nxt.adm.attr = scr_pkg::strb_merge(st_r.adm.attr, wr_data,
            wr_strb);
        end
        scr_pkg::OFF_ADM_SUB_LO: begin
          st_nxt.adm.sub_lo = scr_pkg::strb_merge(st_r.adm.sub_lo,
            wr_data, wr_strb);
        end
        scr_pkg::OFF_ADM_SUB_HI: begin
          st_nxt.adm.sub_hi = scr_pkg::strb_merge(st_r.adm.sub_hi,
            wr_data, wr_strb);
        end
        scr_pkg::OFF_ADM_CPL_LO: begin
          st_nxt.adm.cpl_lo = scr_pkg::strb_merge(st_r.adm.cpl_lo,
            wr_data, wr_strb);
        end
        scr_pkg::OFF_ADM_CPL_HI: begin
          st_nxt.adm.cpl_hi = scr_pkg::strb_merge(st_r.adm.cpl_hi,
            wr_data, wr_strb);
        end
        scr_pkg::OFF_IRQ_ST: begin
          if (wr_strb[0]) begin
            st_nxt.ist = st_r.ist & ~wr_data[scr_pkg::NEV-1:0];
          end
        end
        scr_pkg::OFF_IRQ_MSK: begin
          wv = scr_pkg::strb_merge({26'h0, st_r.imsk}, wr_data, wr_strb);
          st_nxt.imsk = wv[scr_pkg::NEV-1:0];
        end
        default: begin
        end
      endcase
    end
    // vendor event also starts a subsystem reset.
    if (vnd_s) begin
      ssr_go = 1'b1;
    end
    if (ssr_go) begin
      st_nxt.ssr_cnt = SSR_CW'(SSR_CYCLES);
      // occurred flag is set, winning over a clear.
      st_nxt.ssro = 1'b1;
      // link ports return to detect only on a start made while the counter is idle.
      st_nxt.det = (st_r.ssr_cnt == '0);
    end else if (st_r.ssr_cnt != '0) begin
      st_nxt.ssr_cnt = st_r.ssr_cnt - SSR_CW'(1);
    end
    src[scr_pkg::EV_SSR] = ssr_go || (st_r.ssr_cnt != '0);
    src[scr_pkg::EV_CONV] = conv_s;
    src[scr_pkg::EV_LINK] = link_s;
    src[scr_pkg::EV_FLR] = flr_s;
    src[scr_pkg::EV_EN] = en_fall;
    ev[scr_pkg::NSRC-1:0] = src & ~st_r.src_prev;
    st_nxt.src_prev = src;
    // sources other than enable reset config space.
    // the same sources drop host communication.
    if (|src[scr_pkg::EV_FLR:scr_pkg::EV_SSR]) begin
      st_nxt.cfgr = 1'b1;
      st_nxt.lost = 1'b1;
    end
    unique case (st_r.ph)
      scr_pkg::PH_RUN: begin
        if (|src) begin
          // any source enters the controller reset.
          st_nxt.ph = scr_pkg::PH_DRAIN;
          st_nxt.crst = 1'b1;
          st_nxt.qdel = 1'b1;
          st_nxt.cause = src;
        end else if (st_r.enable && !st_r.rdy && core_idle) begin
          st_nxt.rdy = 1'b1;
          ev[scr_pkg::EV_RDY] = 1'b1;
        end
      end
      scr_pkg::PH_DRAIN: begin
        st_nxt.cause = st_r.cause | src;
        // ready clears only after idle is reached.
        if (core_idle) begin
          st_nxt.ph = scr_pkg::PH_HOLD;
          st_nxt.rdy = 1'b0;
          // admin queue registers are left alone.
          st_nxt.enable = 1'b0;
        end
      end
      scr_pkg::PH_HOLD: begin
        st_nxt.cause = st_r.cause | src;
        // merged request releases when all sources are gone.
        if (!(|src)) begin
          st_nxt.ph = scr_pkg::PH_RUN;
          st_nxt.crst = 1'b0;
          st_nxt.cfgr = 1'b0;
          st_nxt.lost = 1'b0;
        end
      end
      default: begin
        st_nxt.ph = scr_pkg::PH_RUN;
      end
    endcase
    // deletion aborts the named queue's commands.
    if (qdel_cmd_valid && st_r.ph == scr_pkg::PH_RUN) begin
      st_nxt.abv = 1'b1;
      st_nxt.abq = qdel_cmd_qid;
    end
    // Events set sticky bits after any clear, so a set wins.
    st_nxt.ist = st_nxt.ist | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
  end

  // State register; power-on reset leaves the occurred flag clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ph <= scr_pkg::PH_RUN;
      st_r.adm <= {5{scr_pkg::REG_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctrl_reset = st_r.crst;
  assign io_queues_delete = st_r.qdel;
  assign cfg_space_reset = st_r.cfgr;
  assign host_link_lost = st_r.lost;
  assign pcie_detect_req = st_r.det;
  assign controller_enable_bit = st_r.enable;
  assign controller_ready_flag = st_r.rdy;
  assign admin_regs = st_r.adm;
  assign qabort_valid = st_r.abv;
  assign qabort_qid = st_r.abq;
  assign irq = st_r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_key_starts_ssr: assert property (
    (SSR_SUPPORTED && wr_pulse && wr_addr == scr_pkg::OFF_SSR_KEY
     && wr_strb == 4'hf && wr_data == scr_pkg::SSR_KEY)
    |=> st_r.ssr_cnt == SSR_CW'(SSR_CYCLES))
    else $error("key write did not start subsystem reset");

  a_detect_resets: assert property (
    st_r.det |-> st_r.crst ##1 st_r.crst)
    else $error("detect request without controller reset");

  a_ssro_on_detect: assert property (
    st_r.det |-> st_r.ssro)
    else $error("occurred flag not set by subsystem reset");

  a_conv_resets: assert property (
    (st_r.ph == scr_pkg::PH_RUN && conv_s) |=> st_r.crst && st_r.qdel)
    else $error("bus reset did not start controller reset");

  a_rdy_until_idle: assert property (
    (st_r.ph == scr_pkg::PH_DRAIN && st_r.rdy && !core_idle)
    |=> st_r.rdy)
    else $error("ready cleared before idle");

  a_rdy_at_idle: assert property (
    (st_r.ph == scr_pkg::PH_DRAIN && core_idle)
    |=> !st_r.rdy && !st_r.enable && st_r.ph == scr_pkg::PH_HOLD)
    else $error("idle did not clear ready and enable");

  a_admin_kept: assert property (
    (st_r.ph == scr_pkg::PH_DRAIN && core_idle && !wr_pulse)
    |=> st_r.adm == $past(st_r.adm))
    else $error("admin queue registers changed by reset");

  a_en_only_cfg: assert property (
    (st_r.ph == scr_pkg::PH_RUN && en_fall && src[3:0] == 4'h0
     && !st_r.cfgr) |=> !st_r.cfgr && !st_r.lost)
    else $error("enable reset touched config space");

  a_abort_queue: assert property (
    (qdel_cmd_valid && st_r.ph == scr_pkg::PH_RUN)
    |=> st_r.abv && st_r.abq == $past(qdel_cmd_qid))
    else $error("queue deletion did not abort");

  a_merge_hold: assert property (
    (st_r.ph != scr_pkg::PH_RUN && (|src)) |=> st_r.crst)
    else $error("controller reset released with source active");

endmodule

`default_nettype wire

// >>> verilog/scr_pkg.sv
package scr_pkg;

  // Subsystem reset key and reset pulse timing.
  localparam logic [31:0] SSR_KEY = 32'h4e564d65;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SSR_PULSE_NS = 1000;
  localparam int SSR_CYC = (SSR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] OFF_CAP = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h14;
  localparam logic [7:0] OFF_STS = 8'h1c;
  localparam logic [7:0] OFF_SSR_KEY = 8'h20;
  localparam logic [7:0] OFF_ADM_ATTR = 8'h24;
  localparam logic [7:0] OFF_ADM_SUB_LO = 8'h28;
  localparam logic [7:0] OFF_ADM_SUB_HI = 8'h2c;
  localparam logic [7:0] OFF_ADM_CPL_LO = 8'h30;
  localparam logic [7:0] OFF_ADM_CPL_HI = 8'h34;
  localparam logic [7:0] OFF_IRQ_ST = 8'h40;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h44;
  localparam logic [7:0] OFF_CAUSE = 8'h48;

  // Field positions, event numbering and reset values.
  localparam int CAP_SSRS_BIT = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int STS_RDY_BIT = 0;
  localparam int STS_SSR_SEEN_BIT = 4;
  localparam int NSRC = 5;
  localparam int NEV = 6;
  localparam int EV_SSR = 0;
  localparam int EV_CONV = 1;
  localparam int EV_LINK = 2;
  localparam int EV_FLR = 3;
  localparam int EV_EN = 4;
  localparam int EV_RDY = 5;
  localparam logic [31:0] REG_RST = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PH_RUN, PH_DRAIN, PH_HOLD} scr_phase_t;

  typedef struct packed {
    logic [31:0] attr;
    logic [31:0] sub_hi;
    logic [31:0] sub_lo;
    logic [31:0] cpl_hi;
    logic [31:0] cpl_lo;
  } scr_admin_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } scr_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scr_axi_s2m_t;

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

  // True for every mapped register offset.
  function automatic logic reg_known(input logic [7:0] a);
    return a inside {OFF_CAP, OFF_CFG, OFF_STS, OFF_SSR_KEY, OFF_ADM_ATTR,
      OFF_ADM_SUB_LO, OFF_ADM_SUB_HI, OFF_ADM_CPL_LO, OFF_ADM_CPL_HI,
      OFF_IRQ_ST, OFF_IRQ_MSK, OFF_CAUSE};
  endfunction

endpackage

// >>> verilog/scr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module scr_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scr_sync_st_t;

  scr_sync_st_t st_r;
  scr_sync_st_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Both stages clear on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

`default_nettype wire

// >>> verilog/scr_axil.sv
`timescale 1ns/1ps
`default_nettype none

module scr_axil (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus side.
  input wire scr_pkg::scr_axi_m2s_t m2s,
  output var scr_pkg::scr_axi_s2m_t s2m,
  // Register file side.
  output logic wr_pulse,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  typedef struct packed {
    scr_pkg::scr_axi_s2m_t o;
    logic awh;
    logic wh;
    logic arh;
    logic wp;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] araddr;
  } scr_axil_st_t;

  scr_axil_st_t st_r;
  scr_axil_st_t st_nxt;

  // Address and data are held independently; a write fires when both are in.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wp = 1'b0;
    if (m2s.awvalid && st_r.o.awready) begin
      st_nxt.awh = 1'b1;
      st_nxt.awaddr = m2s.awaddr;
    end
    if (m2s.wvalid && st_r.o.wready) begin
      st_nxt.wh = 1'b1;
      st_nxt.wdata = m2s.wdata;
      st_nxt.wstrb = m2s.wstrb;
    end
    if (st_r.awh && st_r.wh) begin
      st_nxt.awh = 1'b0;
      st_nxt.wh = 1'b0;
      st_nxt.wp = 1'b1;
      st_nxt.o.bvalid = 1'b1;
      st_nxt.o.bresp = wr_err ? scr_pkg::RESP_SLVERR : scr_pkg::RESP_OKAY;
    end else if (st_r.o.bvalid && m2s.bready) begin
      st_nxt.o.bvalid = 1'b0;
    end
    if (m2s.arvalid && st_r.o.arready) begin
      st_nxt.arh = 1'b1;
      st_nxt.araddr = m2s.araddr;
    end
    if (st_r.arh) begin
      st_nxt.arh = 1'b0;
      st_nxt.o.rvalid = 1'b1;
      st_nxt.o.rdata = rd_data;
      st_nxt.o.rresp = rd_err ? scr_pkg::RESP_SLVERR : scr_pkg::RESP_OKAY;
    end else if (st_r.o.rvalid && m2s.rready) begin
      st_nxt.o.rvalid = 1'b0;
    end
    st_nxt.o.awready = !st_nxt.awh && !st_nxt.wp && !st_nxt.o.bvalid;
    st_nxt.o.wready = !st_nxt.wh && !st_nxt.wp && !st_nxt.o.bvalid;
    st_nxt.o.arready = !st_nxt.arh && !st_nxt.o.rvalid;
  end

  // All ready flags start low and rise one cycle after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s2m = st_r.o;
  assign wr_pulse = st_r.wp;
  assign wr_addr = st_r.awaddr;
  assign wr_data = st_r.wdata;
  assign wr_strb = st_r.wstrb;
  assign rd_addr = st_r.araddr;

endmodule

`default_nettype wire

// >>> bench/scr_host.sv
`timescale 1ns/1ps
`default_nettype none

module scr_host (
  // Clock and controller status.
  input wire logic aclk,
  input wire logic rdy,
  // Register bus, master side.
  output var scr_pkg::scr_axi_m2s_t m2s,
  input wire scr_pkg::scr_axi_s2m_t s2m
);
  // The bus starts idle.
  initial m2s = '0;

  // Write one word; address and data go out together, each held until taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    m2s.awaddr <= a;
    m2s.awvalid <= 1'b1;
    m2s.wdata <= d;
    m2s.wstrb <= 4'hf;
    m2s.wvalid <= 1'b1;
    m2s.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s2m.awready === 1'b1) begin
        aw_ok = 1'b1;
        m2s.awvalid <= 1'b0;
      end
      if (!w_ok && s2m.wready === 1'b1) begin
        w_ok = 1'b1;
        m2s.wvalid <= 1'b0;
      end
    end
    while (s2m.bvalid !== 1'b1) @(posedge aclk);
    r = s2m.bresp;
    m2s.bready <= 1'b0;
    @(posedge aclk); // An edge passes before the next call raises it.
  endtask

  // Read one word; rready stays high until the data is taken.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    m2s.araddr <= a;
    m2s.arvalid <= 1'b1;
    m2s.rready <= 1'b1;
    do @(posedge aclk); while (s2m.arready !== 1'b1);
    m2s.arvalid <= 1'b0;
    do @(posedge aclk); while (s2m.rvalid !== 1'b1);
    d = s2m.rdata;
    r = s2m.rresp;
    m2s.rready <= 1'b0;
    @(posedge aclk); // An edge passes before the next call raises it.
  endtask

  task automatic bring_up(output logic ok);
    logic [1:0] r;
    wr(scr_pkg::OFF_CFG, 32'h1, r);
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge aclk);
      ok = (rdy === 1'b1);
    end
  endtask
endmodule

`default_nettype wire

// >>> bench/scr_rst_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module scr_rst_ctrl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] pins = 4'h0;
  logic core_idle = 1'b1;
  logic qdel_v = 1'b0;
  logic [15:0] qdel_q = 16'h0;
  scr_pkg::scr_axi_m2s_t m2s;
  scr_pkg::scr_axi_s2m_t s2m;
  scr_pkg::scr_admin_t adm;
  logic crst, qall, cfg, lost, det, en, rdy, qab, irq, ok;
  logic [15:0] qab_q;
  logic [2:0] mon;
  int miscompares = 0;
  int compares = 0;
  int qd_n = 0;
  int det_n = 0;
  int qab_n = 0;
  int q0, d0;

  // Signals that the bench waits on.
  assign mon = {irq, rdy, crst};

  // Clock of 100 ns period.
  always #50 aclk = ~aclk;

  scr_host u_host (.aclk(aclk), .rdy(rdy), .m2s(m2s), .s2m(s2m));

  scr_rst_ctrl #(.SSR_CYCLES(3)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .axi_m2s(m2s), .axi_s2m(s2m),
    .conv_rst_req(pins[0]), .link_down(pins[1]), .flr_req(pins[2]),
    .vendor_ssr_evt(pins[3]), .core_idle(core_idle),
    .qdel_cmd_valid(qdel_v), .qdel_cmd_qid(qdel_q), .ctrl_reset(crst),
    .io_queues_delete(qall), .cfg_space_reset(cfg),
    .host_link_lost(lost), .pcie_detect_req(det),
    .controller_enable_bit(en), .controller_ready_flag(rdy),
    .admin_regs(adm), .qabort_valid(qab), .qabort_qid(qab_q), .irq(irq));

  // Count the one-cycle pulses so that doubles are caught.
  always @(posedge aclk) begin
    if (qall === 1'b1) qd_n++;
    if (det === 1'b1) det_n++;
    if (qab === 1'b1) qab_n++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    logic [31:0] dd;
    logic [1:0] rr;
    u_host.rd(a, dd, rr);
    chk($sformatf("rdata_%h", a), e, dd);
    chk($sformatf("rresp_%h", a), {30'h0, er}, {30'h0, rr});
  endtask

  task automatic wrchk(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er);
    logic [1:0] rr;
    u_host.wr(a, v, rr);
    chk($sformatf("bresp_%h", a), {30'h0, er}, {30'h0, rr});
  endtask

  // Bounded wait for a watched signal to reach a level.
  task automatic waitfor(input int i, input logic v, input string nm);
    for (int n = 0; n < 100 && mon[i] !== v; n++) @(posedge aclk);
    chk(nm, {31'h0, v}, {31'h0, mon[i]});
  endtask

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rdchk(scr_pkg::OFF_CAP, 32'h1, 2'h0);
    rdchk(scr_pkg::OFF_STS, 32'h0, 2'h0);
    rdchk(8'h50, 32'h0, 2'h2);
    wrchk(8'h50, 32'h1, 2'h2);
    wrchk(scr_pkg::OFF_ADM_ATTR, 32'h001f001f, 2'h0);
    wrchk(scr_pkg::OFF_ADM_SUB_LO, 32'habcd1000, 2'h0);
    u_host.bring_up(ok);
    chk("ready_up", 32'h1, {31'h0, ok});
    // Enable reset while the core is still busy.
    // the busy core's commands count as lost; the host rebuilds.
    q0 = qd_n;
    core_idle <= 1'b0;
    wrchk(scr_pkg::OFF_CFG, 32'h0, 2'h0);
    waitfor(0, 1'b1, "ctrl_reset_on");
    repeat (4) @(posedge aclk);
    chk("ready_draining", 32'h1, {31'h0, rdy});
    chk("cfg_reset_en", 32'h0, {31'h0, cfg});
    chk("link_lost_en", 32'h0, {31'h0, lost});
    core_idle <= 1'b1;
    waitfor(1, 1'b0, "ready_off");
    waitfor(0, 1'b0, "ctrl_reset_off");
    chk("qdel_pulse_en", q0 + 1, qd_n);
    rdchk(scr_pkg::OFF_ADM_ATTR, 32'h001f001f, 2'h0);
    chk("sub_lo_kept", 32'habcd1000, adm.sub_lo);
    rdchk(scr_pkg::OFF_CFG, 32'h0, 2'h0);
    // Every pin source in turn.
    for (int i = 0; i < 4; i++) begin
      u_host.bring_up(ok);
      chk("ready_up", 32'h1, {31'h0, ok});
      q0 = qd_n;
      d0 = det_n;
      pins[i] <= 1'b1;
      waitfor(0, 1'b1, "ctrl_reset_pin");
      chk("cfg_reset_pin", 32'h1, {31'h0, cfg});
      chk("link_lost_pin", 32'h1, {31'h0, lost});
      @(posedge aclk);
      pins <= 4'h0;
      waitfor(0, 1'b0, "ctrl_reset_off");
      chk("enable_cleared", 32'h0, {31'h0, en});
      chk("qdel_pulse", q0 + 1, qd_n);
      chk("detect_pulse", d0 + (i == 3), det_n);
      rdchk(scr_pkg::OFF_CAUSE, 32'h1 << ((i + 1) % 4), 2'h0);
    end
    rdchk(scr_pkg::OFF_STS, 32'h10, 2'h0);
    wrchk(scr_pkg::OFF_STS, 32'h10, 2'h0);
    rdchk(scr_pkg::OFF_STS, 32'h0, 2'h0);
    // A wrong key does nothing, the right key resets the subsystem.
    d0 = det_n;
    wrchk(scr_pkg::OFF_SSR_KEY, 32'h4e564d64, 2'h0);
    repeat (5) @(posedge aclk);
    chk("no_reset_bad_key", 32'h0, {31'h0, crst});
    wrchk(scr_pkg::OFF_SSR_KEY, scr_pkg::SSR_KEY, 2'h0);
    waitfor(0, 1'b1, "ctrl_reset_key");
    waitfor(0, 1'b0, "ctrl_reset_off");
    chk("detect_key", d0 + 1, det_n);
    rdchk(scr_pkg::OFF_STS, 32'h10, 2'h0);
    rdchk(scr_pkg::OFF_SSR_KEY, 32'h0, 2'h0);
    // Two sources overlap and merge into one reset.
    q0 = qd_n;
    pins <= 4'h6;
    waitfor(0, 1'b1, "ctrl_reset_merge");
    pins <= 4'h4;
    repeat (6) @(posedge aclk);
    chk("merged_hold", 32'h1, {31'h0, crst});
    pins <= 4'h0;
    waitfor(0, 1'b0, "ctrl_reset_off");
    chk("merged_pulse", q0 + 1, qd_n);
    // Queue deletion aborts; it is refused during a reset.
    // a queue pair is deleted by two back-to-back commands, core idle.
    q0 = qab_n;
    qdel_q <= 16'h0005;
    qdel_v <= 1'b1;
    @(posedge aclk);
    qdel_q <= 16'h0004;
    @(posedge aclk);
    chk("abort_qid", 32'h5, {16'h0, qab_q});
    qdel_v <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("abort_pulse", q0 + 2, qab_n);
    chk("abort_qid_pair", 32'h4, {16'h0, qab_q});
    pins <= 4'h2;
    waitfor(0, 1'b1, "ctrl_reset_on");
    qdel_q <= 16'h0009;
    qdel_v <= 1'b1;
    @(posedge aclk);
    qdel_v <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("abort_refused", q0 + 2, qab_n);
    chk("abort_qid_kept", 32'h4, {16'h0, qab_q});
    pins <= 4'h0;
    waitfor(0, 1'b0, "ctrl_reset_off");
    // Interrupt: masked event, unmasked event, clear.
    wrchk(scr_pkg::OFF_IRQ_ST, 32'h3f, 2'h0);
    wrchk(scr_pkg::OFF_IRQ_MSK, 32'h4, 2'h0);
    u_host.bring_up(ok);
    rdchk(scr_pkg::OFF_IRQ_ST, 32'h20, 2'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    pins <= 4'h2;
    waitfor(2, 1'b1, "irq_on");
    pins <= 4'h0;
    waitfor(0, 1'b0, "ctrl_reset_off");
    wrchk(scr_pkg::OFF_IRQ_ST, 32'h4, 2'h0);
    waitfor(2, 1'b0, "irq_off");
    summarize();
  end
endmodule

`default_nettype wire
